// ---- ipg_pkg.sv ----
// Package with register map, field layout and guard codes of the interrupt pin and write guard block
package ipg_pkg;
    localparam logic [6:0] ADDR_IRQ_PIN_CONFIG = 7'h7d;
    localparam logic [6:0] ADDR_WRITE_GUARD = 7'h7e;
    localparam int BIT_ACTIVE_LEVEL = 0;
    localparam int BIT_IDLE_FLOAT = 1;
    localparam int BIT_PIN_REPURPOSE = 2;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h07;
    localparam logic [7:0] RST_IRQ_PIN_CONFIG = 8'h02;
    localparam logic [7:0] RST_WRITE_GUARD = 8'h85;
    localparam logic [7:0] GUARD_FULL_OPEN = 8'h85;
    localparam logic [7:0] GUARD_SINGLE_OPEN = 8'h86;
    localparam logic [7:0] GUARD_RELOCK = 8'h00;
endpackage

// ---- ipg_top.sv ----
// Interrupt pin configuration register and register write guard
`timescale 1ns/1ps
module ipg_top #(
    parameter int ADDR_W = 7
) (
    input wire logic clk_i,               // 25 MHz device clock
    input wire logic nrst_i,              // Asynchronous reset, active low
    input wire logic wr_en_i,             // Register write strobe, one cycle
    input wire logic rd_en_i,             // Register read strobe, one cycle
    input wire logic [ADDR_W-1:0] addr_i, // Register address
    input wire logic [7:0] wdata_i,       // Write data
    output logic [7:0] rdata_o,           // Read data, valid cycle after rd_en_i
    output logic ext_write_ok_o,          // Writes to other registers allowed now
    output logic ext_write_o,             // Pulse: accepted write to another register
    input wire logic irq_req_i,           // Combined interrupt request, active high
    output logic irq_pin_o,               // Interrupt pin output value
    output logic irq_pin_oe_o             // Interrupt pin output enable, high drives
);
    typedef enum logic [1:0] {
        IPG_GUARD_LOCKED,
        IPG_GUARD_FULL_OPEN,
        IPG_GUARD_SINGLE_OPEN
    } ipg_guard_mode_e;

    typedef struct packed {
        logic repurpose;
        logic idle_float;
        logic active_high;
    } ipg_pin_cfg_s;

    logic [7:0] cfg_q;
    logic [7:0] guard_q;
    logic [7:0] rdata_q;

    ipg_guard_mode_e guard_mode;
    ipg_pin_cfg_s pin_cfg;
    logic guard_hit;
    logic cfg_hit;
    logic other_hit;
    logic open_now;
    logic write_accept;
    logic relock_now;
    logic pin_active;

    // Compare at the port width so a narrower address bus still decodes the map
    function automatic logic addr_match(
        input logic [ADDR_W-1:0] addr,
        input logic [6:0] target
    );
        return addr == ADDR_W'(target);
    endfunction

    // Only two codes open the device; every other value protects it
    function automatic ipg_guard_mode_e decode_guard(
        input logic [7:0] code
    );
        ipg_guard_mode_e mode;
        mode = IPG_GUARD_LOCKED;
        case (code)
            ipg_pkg::GUARD_FULL_OPEN: begin
                mode = IPG_GUARD_FULL_OPEN;
            end
            ipg_pkg::GUARD_SINGLE_OPEN: begin
                mode = IPG_GUARD_SINGLE_OPEN;
            end
            default: begin
                mode = IPG_GUARD_LOCKED;
            end
        endcase
        return mode;
    endfunction

    // Both open modes pass the same writes; they differ only in what follows
    function automatic logic mode_open(
        input ipg_guard_mode_e mode
    );
        return mode != IPG_GUARD_LOCKED;
    endfunction

    // Bits 7 to 3 are not implemented, so they are dropped before storing
    function automatic logic [7:0] cfg_written(
        input logic [7:0] data
    );
        return data & ipg_pkg::CFG_WRITE_MASK;
    endfunction

    // Named fields keep the bit positions in one place
    function automatic ipg_pin_cfg_s unpack_cfg(
        input logic [7:0] cfg
    );
        ipg_pin_cfg_s fields;
        fields.repurpose = cfg[ipg_pkg::BIT_PIN_REPURPOSE];
        fields.idle_float = cfg[ipg_pkg::BIT_IDLE_FLOAT];
        fields.active_high = cfg[ipg_pkg::BIT_ACTIVE_LEVEL];
        return fields;
    endfunction

    // In repurpose mode the level bit is the pin value and counts as active
    function automatic logic pin_is_active(
        input ipg_pin_cfg_s cfg,
        input logic req
    );
        logic active;
        active = req;
        if (cfg.repurpose) begin
            active = 1'b1;
        end
        return active;
    endfunction

    function automatic logic pin_value(
        input ipg_pin_cfg_s cfg,
        input logic req
    );
        logic value;
        logic level;
        level = cfg.active_high;
        value = level;
        if (cfg.repurpose) begin
            value = level;
        end else if (req) begin
            value = level;
        end else begin
            value = ~level;
        end
        return value;
    endfunction

    // A floating idle pin lets several sources share one wire
    function automatic logic pin_enable(
        input ipg_pin_cfg_s cfg,
        input logic active
    );
        logic drive;
        drive = 1'b1;
        if (cfg.idle_float) begin
            drive = active;
        end
        return drive;
    endfunction

    // Unmapped addresses read as zero rather than a stale value
    function automatic logic [7:0] read_value(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] cfg,
        input logic [7:0] guard
    );
        logic [7:0] value;
        value = 8'h00;
        if (addr_match(addr, ipg_pkg::ADDR_IRQ_PIN_CONFIG)) begin
            value = cfg;
        end else if (addr_match(addr, ipg_pkg::ADDR_WRITE_GUARD)) begin
            value = guard;
        end
        return value;
    endfunction

    assign guard_hit = wr_en_i && addr_match(addr_i, ipg_pkg::ADDR_WRITE_GUARD);
    assign cfg_hit = wr_en_i && addr_match(addr_i, ipg_pkg::ADDR_IRQ_PIN_CONFIG);
    assign other_hit = wr_en_i && !guard_hit;

    assign guard_mode = decode_guard(guard_q);
    assign open_now = mode_open(guard_mode);
    assign write_accept = other_hit && open_now;
    // Any accepted write spends the single-open code, mapped here or not
    assign relock_now = write_accept && (guard_mode == IPG_GUARD_SINGLE_OPEN);
    assign ext_write_ok_o = open_now;
    assign ext_write_o = write_accept;

    // Blocked writes leave the pin configuration untouched
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_q <= ipg_pkg::RST_IRQ_PIN_CONFIG;
        end else if (cfg_hit && open_now) begin
            cfg_q <= cfg_written(wdata_i);
        end
    end

    // Guard writes always land, so software can always unlock
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            guard_q <= ipg_pkg::RST_WRITE_GUARD;
        end else if (guard_hit) begin
            // A guard write during single-open simply loads the new code
            guard_q <= wdata_i;
        end else if (relock_now) begin
            guard_q <= ipg_pkg::GUARD_RELOCK;
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
        end else if (rd_en_i) begin
            rdata_q <= read_value(addr_i, cfg_q, guard_q);
        end
    end
    assign rdata_o = rdata_q;

    // Pin follows the request at once; no flop sits between request and pin
    assign pin_cfg = unpack_cfg(cfg_q);
    always_comb begin
        pin_active = pin_is_active(pin_cfg, irq_req_i);
        irq_pin_o = pin_value(pin_cfg, irq_req_i);
        irq_pin_oe_o = pin_enable(pin_cfg, pin_active);
    end
endmodule

// ---- ipg_sva.sv ----
// Checker for the pin and write guard block
`timescale 1ns/1ps
module ipg_sva (
    input wire logic clk_i, // Device clock
    input wire logic nrst_i, // Reset, active low
    input wire logic wr_en_i, // Write strobe
    input wire logic rd_en_i, // Read strobe
    input wire logic [6:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic [7:0] rdata_o, // Read data
    input wire logic ext_write_ok_o, // Writes allowed now
    input wire logic ext_write_o, // Accepted write pulse
    input wire logic irq_req_i, // Interrupt request
    input wire logic irq_pin_oe_o // Pin output enable
);
    logic single_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Single-open code seen on the bus and not yet spent
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            single_q <= 1'b0;
        end else if (wr_en_i && addr_i == ipg_pkg::ADDR_WRITE_GUARD) begin
            single_q <= (wdata_i == ipg_pkg::GUARD_SINGLE_OPEN);
        end else if (wr_en_i) begin
            single_q <= 1'b0;
        end
    end
    property p_blk; wr_en_i && addr_i != ipg_pkg::ADDR_WRITE_GUARD && !ext_write_ok_o |-> !ext_write_o; endproperty
    a_blk: assert property (p_blk) else $error("blocked write was accepted");
    property p_opn; wr_en_i && addr_i != ipg_pkg::ADDR_WRITE_GUARD && ext_write_ok_o |-> ext_write_o; endproperty
    a_opn: assert property (p_opn) else $error("open write was dropped");
    property p_grd; wr_en_i && addr_i == ipg_pkg::ADDR_WRITE_GUARD |=>
        ext_write_ok_o == ($past(wdata_i) == ipg_pkg::GUARD_FULL_OPEN || $past(wdata_i) == ipg_pkg::GUARD_SINGLE_OPEN);
    endproperty
    a_grd: assert property (p_grd) else $error("guard code gave wrong mode");
    property p_act; irq_req_i |-> irq_pin_oe_o; endproperty
    a_act: assert property (p_act) else $error("active pin not driven");
    property p_rlk; single_q && wr_en_i && addr_i != ipg_pkg::ADDR_WRITE_GUARD |=> !ext_write_ok_o; endproperty
    a_rlk: assert property (p_rlk) else $error("single open did not relock");
    property p_hld; wr_en_i && addr_i != ipg_pkg::ADDR_WRITE_GUARD && !ext_write_ok_o |=> $stable(ext_write_ok_o);
    endproperty
    a_hld: assert property (p_hld) else $error("blocked write changed the guard");
    property p_rsv; rd_en_i && addr_i == ipg_pkg::ADDR_IRQ_PIN_CONFIG |=> rdata_o[7:3] == 5'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("unused config bits read nonzero");
endmodule
bind ipg_top ipg_sva u_sva (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .ext_write_ok_o(ext_write_ok_o),
    .ext_write_o(ext_write_o),
    .irq_req_i(irq_req_i),
    .irq_pin_oe_o(irq_pin_oe_o)
);

// ---- ipg_host.sv ----
// Host interrupt input on a shared line with pull-up
`timescale 1ns/1ps
module ipg_host (
    input wire logic pin_i, // Pin value from the block
    input wire logic oe_i, // Pin output enable
    output logic line_o // Level the host input sees
);
    // A released line floats up to the pull-up level
    assign line_o = oe_i ? pin_i : 1'b1;
endmodule

// ---- ipg_top_bench.sv ----
// Bench for the pin configuration and write guard block
`timescale 1ns/1ps
module ipg_top_bench;
    logic clk_i = 0, nrst_i = 0, we = 0, re = 0, rq = 0, pin, oe, line, ok, wx;
    logic [6:0] ad = 0;
    logic [7:0] wd = 0, rd;
    int bad_count = 0, n_tests = 0;
    always #20 clk_i = ~clk_i;
    ipg_top uut(.clk_i, .nrst_i, .wr_en_i(we), .rd_en_i(re), .addr_i(ad), .wdata_i(wd), .rdata_o(rd),
        .ext_write_ok_o(ok), .ext_write_o(wx), .irq_req_i(rq), .irq_pin_o(pin), .irq_pin_oe_o(oe));
    ipg_host host(.pin_i(pin), .oe_i(oe), .line_o(line));
    task acc(logic w, logic [6:0] a, logic [7:0] d); @(posedge clk_i) #1; we = w; re = !w; ad = a; wd = d;
        @(posedge clk_i) #1; we = 0; re = 0; endtask
    task chk(logic [7:0] got, exp); n_tests++; if (got !== exp) begin bad_count++;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end endtask
    task rdc(logic [6:0] a, logic [7:0] e); acc(0, a, 8'h00); chk(rd, e); endtask
    // Write whose open flag and accept pulse are judged before the edge that takes it
    task wrc(logic [6:0] a, logic [7:0] d, logic [7:0] e); @(posedge clk_i) #1; we = 1; ad = a; wd = d;
        #1 chk({ok, wx}, e); @(posedge clk_i) #1; we = 0; endtask
    task t_reset;
        rdc(7'h7d, 8'h02);
        rq = 1; #1 chk(line, 8'h00);
        rq = 0; #1 chk({oe, line}, 8'h01);
    endtask
    task t_guard;
        acc(1, 7'h7e, 8'h00); wrc(7'h7d, 8'h07, 8'h00); rdc(7'h7d, 8'h02);
        wrc(7'h7e, 8'h86, 8'h00); wrc(7'h7d, 8'hff, 8'h03); rdc(7'h7d, 8'h07);
        rdc(7'h7e, 8'h00);
        wrc(7'h7d, 8'h00, 8'h00); rdc(7'h7d, 8'h07);
        chk({oe, pin}, 8'h03);
        acc(1, 7'h7e, 8'h85); wrc(7'h7d, 8'h01, 8'h03); rdc(7'h7d, 8'h01);
        chk({oe, pin}, 8'h02);
    endtask
    task t_rerst; @(posedge clk_i) #1; nrst_i = 0; repeat (2) @(posedge clk_i); #1 nrst_i = 1;
        rdc(7'h7d, 8'h02); rdc(7'h7e, 8'h85);
    endtask
    task results; $display("tests %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish; endtask
    initial begin repeat (2) @(posedge clk_i); #1 nrst_i = 1; t_reset; t_guard; t_rerst; results; end
    initial begin #100000; bad_count++; results; end
endmodule
